/* File: logic/irq_regs.vh */
// register map, field positions and timing counts of the interrupt pin block
`ifndef IRQ_REGS_VH
`define IRQ_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PIN_CONFIG_OFS 8'h54
`define STATUS_OFS 8'h58
`define ENABLE_OFS 8'h5c
// ----------------------------------------------------------------
// interrupt_pin_config fields
// ----------------------------------------------------------------
`define CFG_INTERVAL_HI 31
`define CFG_INTERVAL_LO 24
`define CFG_RESTART_BIT 14
`define CFG_ACTIVE_BIT 13
`define CFG_LINE_BIT 12
`define CFG_PIN_EN_BIT 8
`define CFG_POLARITY_BIT 4
`define CFG_CLK_SEL_BIT 1
`define CFG_PUSH_PULL_BIT 0
`define CFG_INTERVAL_RST 8'h00
// ----------------------------------------------------------------
// interrupt_status / interrupt_enable fields
// ----------------------------------------------------------------
`define SOFT_BIT 31
`define READY_BIT 30
`define WRAP_BIT 19
`define POWER_BIT 17
`define TIMER_WRAP_FROM 16'h0000
`define TIMER_WRAP_TO 16'hffff
// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// ----------------------------------------------------------------
// timing: one interval step in ns, clock period in ns, cycles per step
// ----------------------------------------------------------------
`define RELEASE_STEP_NS 10000
`define CLK_PERIOD_NS 100
`define TICK_CYCLES ((`RELEASE_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: logic/step_tick_divider.v */
// divider that makes the 10 us step enable from the system clock
`timescale 1ns/100ps
`include "irq_regs.vh"
module step_tick_divider (
    input wire aclk,
    input wire aresetn,
    input wire restart,
    output reg tick_q
);
    localparam integer STEP_LAST = `TICK_CYCLES - 1;
    localparam [7:0] LAST = STEP_LAST[7:0];
    reg [7:0] count_q; // cycles into the current step

    // ----------------------------------------------------------------
    // step counter; restart realigns so a fresh interval is never short
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (restart) begin
            count_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (count_q == LAST) begin
            count_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            count_q <= count_q + 8'h01;
            tick_q <= 1'b0;
        end
    end
endmodule // step_tick_divider

/* File: logic/release_interval_timer.v */
// de-assertion interval counter that withholds requests from the pin
`timescale 1ns/100ps
module release_interval_timer (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] release_interval,
    input wire start,
    input wire restart,
    input wire tick,
    output reg active_q
);
    reg [7:0] steps_q; // whole steps elapsed in this interval

    // ----------------------------------------------------------------
    // interval state; the live field is compared so new values apply
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            steps_q <= 8'h00;
            active_q <= 1'b0;
        end else if (release_interval == 8'h00) begin
            steps_q <= 8'h00;
            active_q <= 1'b0;
        end else if (start || restart) begin
            steps_q <= 8'h00;
            active_q <= 1'b1;
        end else if (active_q && tick) begin
            // ends on the step that reaches the programmed count
            if (steps_q + 8'h01 >= release_interval) begin
                steps_q <= 8'h00;
                active_q <= 1'b0;
            end else begin
                steps_q <= steps_q + 8'h01;
            end
        end
    end
endmodule // release_interval_timer

/* File: logic/interrupt_pin_aggregator.v */
// interrupt pin aggregator: status, enables, interval gating, axi-lite
//
// Overview of operation
// - timer wrap zero to ffff sets flag
// - timer flag cleared by writing one
// - timer reaches pin: run, enable, pin enable
// - soft flag set on enable rising edge
// - soft flag reaches pin via pin enable
// - ready flag set after reset, w1c
// - ready reaches pin: enable and pin enable
// - clock select drives crystal clock on pin
// - interval field top byte, 10 us steps
// - zero interval disables, clears, releases requests
// - new nonzero interval used at once, also by a running interval
// - power event bypasses interval gating
// - restart bit clears counter, new interval, self-clears
// - active bit shows interval, pin withheld
// - line bit shows any enabled active request
// - pin enable clear holds pin de-asserted unless clock select is set
// - interval starts whenever pin de-asserts
// - power event ored after gating, its de-assertion starts an interval
// - open-drain active low, push-pull with polarity
`timescale 1ns/100ps
`include "irq_regs.vh"
module interrupt_pin_aggregator (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // sources on this clock
    input wire [15:0] timer_count_value,
    input wire timer_run_enable,
    input wire power_event_request,
    // crystal clock to observe, from outside this domain
    input wire xtal_clk,
    // interrupt request pin
    output reg irq_pin_o,
    output reg irq_pin_oe
);
    // ----------------------------------------------------------------
    // merges write data into a word under byte strobes
    // ----------------------------------------------------------------
    function [31:0] lanes;
        input [31:0] data;
        input [3:0] strb;
        begin
            lanes = {{8{strb[3]}}, {8{strb[2]}},
                     {8{strb[1]}}, {8{strb[0]}}} & data;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge = (old & ~lanes(32'hffffffff, strb)) | lanes(data, strb);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0] interval_q; // release_interval field
    reg pin_en_q; // pin enable
    reg polarity_q; // pin_polarity, used only in push-pull
    reg clk_sel_q; // crystal clock onto the pin
    reg push_pull_q; // buffer type
    reg soft_flag_q; // soft_request_flag
    reg ready_flag_q; // device ready flag
    reg wrap_flag_q; // timer_wrap_flag
    reg soft_en_q; // soft_request_enable
    reg ready_en_q; // ready enable
    reg wrap_en_q; // timer_wrap_irq_enable
    reg power_en_q; // power event enable
    reg soft_en_prev_q; // previous soft enable, for edge detect
    reg ready_done_q; // ready flag already raised since reset
    reg [15:0] count_prev_q; // timer count one cycle ago
    reg restart_q; // self-clearing restart pulse
    reg pin_assert_q; // pin asserted, logical sense
    reg line_q; // internal request line
    reg xtal_meta_q; // crystal clock sync, first stage
    reg xtal_sync_q; // crystal clock sync, second stage
    reg [7:0] aw_addr_q; // held write address
    reg aw_full_q; // write address held
    reg [31:0] w_data_q; // held write data
    reg [3:0] w_strb_q; // held write strobes
    reg w_full_q; // write data held

    wire tick; // 10 us step enable
    wire active; // interval in progress
    wire do_write; // both halves of a write are held
    wire [31:0] wmask; // strobed write data
    wire wrap_event; // timer rolled past zero
    wire soft_event; // soft enable rose
    wire ready_event; // device became accessible
    wire gated_src; // requests that obey the interval
    wire power_src; // power request, bypasses the interval
    wire pin_assert_d; // next logical pin state

    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wmask = lanes(w_data_q, w_strb_q);
    // compare against the previous count so a held ffff does not retrigger
    assign wrap_event = (count_prev_q == `TIMER_WRAP_FROM) &&
                        (timer_count_value == `TIMER_WRAP_TO);
    assign soft_event = soft_en_q && !soft_en_prev_q;
    assign ready_event = !ready_done_q;

    // ----------------------------------------------------------------
    // request sources
    // ----------------------------------------------------------------
    assign gated_src = (wrap_flag_q && wrap_en_q && timer_run_enable)
        || soft_flag_q
        || (ready_flag_q && ready_en_q);
    assign power_src = power_event_request && power_en_q;
    // interval withholds only the gated sources; power is ored after
    assign pin_assert_d = pin_en_q &&
        ((gated_src && !active) || power_src);

    // ----------------------------------------------------------------
    // interval step and counter
    // ----------------------------------------------------------------
    step_tick_divider u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(restart_q || (pin_assert_q && !pin_assert_d)),
        .tick_q(tick)
    );

    release_interval_timer u_interval (
        .aclk(aclk),
        .aresetn(aresetn),
        .release_interval(interval_q),
        .start(pin_assert_q && !pin_assert_d),
        .restart(restart_q),
        .tick(tick),
        .active_q(active)
    );

    // ----------------------------------------------------------------
    // crystal clock synchroniser; the pin sees it through three registers
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            xtal_meta_q <= 1'b0;
            xtal_sync_q <= 1'b0;
        end else begin
            xtal_meta_q <= xtal_clk;
            xtal_sync_q <= xtal_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // event history
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_prev_q <= 16'hffff; // no false wrap after reset
            soft_en_prev_q <= 1'b0;
            ready_done_q <= 1'b0;
            pin_assert_q <= 1'b0;
            line_q <= 1'b0;
        end else begin
            count_prev_q <= timer_count_value;
            soft_en_prev_q <= soft_en_q;
            ready_done_q <= 1'b1;
            pin_assert_q <= pin_assert_d;
            // line ignores pin enable and interval
            line_q <= gated_src || power_src;
        end
    end

    // ----------------------------------------------------------------
    // pin driver: open-drain pulls low, push-pull honours polarity
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_pin_o <= 1'b0;
            irq_pin_oe <= 1'b0;
        end else if (clk_sel_q) begin
            // open-drain can only show the low half of the clock
            irq_pin_o <= push_pull_q ? xtal_sync_q : 1'b0;
            irq_pin_oe <= push_pull_q || !xtal_sync_q;
        end else if (push_pull_q) begin
            irq_pin_o <= polarity_q ? pin_assert_q : !pin_assert_q;
            irq_pin_oe <= 1'b1;
        end else begin
            irq_pin_o <= 1'b0;
            irq_pin_oe <= pin_assert_q;
        end
    end

    // ----------------------------------------------------------------
    // status flags: a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            wrap_flag_q <= 1'b0;
            soft_flag_q <= 1'b0;
            ready_flag_q <= 1'b0;
        end else begin
            if (wrap_event) begin
                wrap_flag_q <= 1'b1;
            end else if (do_write && aw_addr_q == `STATUS_OFS &&
                         wmask[`WRAP_BIT]) begin
                wrap_flag_q <= 1'b0;
            end
            if (soft_event) begin
                soft_flag_q <= 1'b1;
            end else if (do_write && aw_addr_q == `STATUS_OFS &&
                         wmask[`SOFT_BIT]) begin
                soft_flag_q <= 1'b0;
            end
            if (ready_event) begin
                ready_flag_q <= 1'b1;
            end else if (do_write && aw_addr_q == `STATUS_OFS &&
                         wmask[`READY_BIT]) begin
                ready_flag_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration and enable registers
    // ----------------------------------------------------------------
    always @(posedge aclk) begin : cfg_regs
        reg [31:0] m;
        m = 32'h00000000;
        if (!aresetn) begin
            interval_q <= `CFG_INTERVAL_RST;
            pin_en_q <= 1'b0;
            polarity_q <= 1'b0;
            clk_sel_q <= 1'b0;
            push_pull_q <= 1'b0;
            restart_q <= 1'b0;
            soft_en_q <= 1'b0;
            ready_en_q <= 1'b0;
            wrap_en_q <= 1'b0;
            power_en_q <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            if (do_write && aw_addr_q == `PIN_CONFIG_OFS) begin
                m = merge({interval_q, 15'h0000, pin_en_q, 3'h0,
                           polarity_q, 2'h0, clk_sel_q, push_pull_q},
                          w_data_q, w_strb_q);
                interval_q <= m[`CFG_INTERVAL_HI:`CFG_INTERVAL_LO];
                restart_q <= wmask[`CFG_RESTART_BIT];
                pin_en_q <= m[`CFG_PIN_EN_BIT];
                polarity_q <= m[`CFG_POLARITY_BIT];
                clk_sel_q <= m[`CFG_CLK_SEL_BIT];
                push_pull_q <= m[`CFG_PUSH_PULL_BIT];
            end
            if (do_write && aw_addr_q == `ENABLE_OFS) begin
                m = merge({soft_en_q, ready_en_q, 10'h000, wrap_en_q,
                           1'b0, power_en_q, 17'h00000},
                          w_data_q, w_strb_q);
                soft_en_q <= m[`SOFT_BIT];
                ready_en_q <= m[`READY_BIT];
                wrap_en_q <= m[`WRAP_BIT];
                power_en_q <= m[`POWER_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // axi-lite write channel: address and data taken in either order
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr_q)
                    `PIN_CONFIG_OFS, `STATUS_OFS, `ENABLE_OFS: begin
                        s_axi_bresp <= `RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `RESP_SLVERR; // unmapped
                    end
                endcase
            end
            // new request is taken only after the response is accepted
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // axi-lite read channel
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `PIN_CONFIG_OFS: begin
                    // restart bit always reads zero
                    s_axi_rdata <= {interval_q, 10'h000, active,
                                    line_q, 3'h0, pin_en_q, 3'h0,
                                    polarity_q, 2'h0, clk_sel_q,
                                    push_pull_q};
                end
                `STATUS_OFS: begin
                    s_axi_rdata <= {soft_flag_q, ready_flag_q, 10'h000,
                                    wrap_flag_q, 1'b0, power_event_request,
                                    17'h00000};
                end
                `ENABLE_OFS: begin
                    s_axi_rdata <= {soft_en_q, ready_en_q, 10'h000,
                                    wrap_en_q, 1'b0, power_en_q,
                                    17'h00000};
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // interrupt_pin_aggregator

/* File: testbench/irq_host.sv */
// host side model: the interrupt wire as the processor sees it
`timescale 1ns/100ps
module irq_host (
    input wire irq_pin_o,
    input wire irq_pin_oe,
    output wire pin
);
    // a released pin floats to the board pull-up, so idle reads high
    assign pin = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule // irq_host

/* File: testbench/irq_pin_asserts.sv */
// port level checker for the interrupt pin aggregator
`timescale 1ns/100ps
`include "irq_regs.vh"
module irq_pin_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire irq_pin_o,
    input wire irq_pin_oe
);
    // ------------------------------------------------------------
    // one clock domain, so clocking and disable are shared
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire mapped = s_axi_araddr[7:2] inside {6'h15, 6'h16, 6'h17};
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_R_NEXT: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer repeated");
    AST_R_BAD: assert property (rd_take and !mapped |=>
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_R_OK: assert property (rd_take and mapped |=>
        s_axi_rresp == `RESP_OKAY) else $error("mapped read refused");
    AST_B_NEXT: assert property (wr_take |=>
        !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
    AST_OD_LOW: assert property (!irq_pin_oe |-> !irq_pin_o)
        else $error("released pin carries high");
    AST_RST_PIN: assert property ($rose(aresetn) |-> !irq_pin_oe)
        else $error("pin driven after reset");
endmodule // irq_pin_checker
bind interrupt_pin_aggregator irq_pin_checker chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_pin_o, .irq_pin_oe);

/* File: testbench/testbench.sv */
// register and pin level testbench of the interrupt pin aggregator
`timescale 1ns/100ps
`include "irq_regs.vh"
module testbench;
    localparam [7:0] CF = `PIN_CONFIG_OFS;
    localparam [7:0] ST = `STATUS_OFS;
    localparam [7:0] EN = `ENABLE_OFS;
    logic aclk = 1'b0, aresetn = 1'b0, xtal = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 32'h0, rd;
    logic [15:0] cnt = 16'h0005; // timer count, away from the wrap
    logic run = 0, pw = 0;
    logic [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer n_fail = 0, compares = 0, i, n;
    interrupt_pin_aggregator dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_count_value(cnt),
        .timer_run_enable(run), .power_event_request(pw), .xtal_clk(xtal),
        .irq_pin_o(pin_o), .irq_pin_oe(pin_oe));
    irq_host host (.irq_pin_o(pin_o), .irq_pin_oe(pin_oe), .pin(pin));
    // ------------------------------------------------------------
    // clocks: crystal deliberately off any multiple of aclk
    // ------------------------------------------------------------
    initial forever #50 aclk = ~aclk;
    initial #23 forever #370 xtal = ~xtal;
    // ------------------------------------------------------------
    // verdict, compare and bus tasks
    // ------------------------------------------------------------
    task summarize;
        $display("mismatches %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ready is sampled on the falling edge, valid dropped on the next rise
    task wr(input [7:0] a, input [31:0] d);
        logic ta, tw, tb;
        integer k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        tb = 0;
        for (k = 0; k < 40 && !tb; k++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) bready <= 0;
        end
        if (!tb) n_fail++;
    endtask
    task rdr(input [7:0] a);
        logic ta, tr;
        integer k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        tr = 0;
        for (k = 0; k < 40 && !tr; k++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (tr) rready <= 0;
        end
        if (!tr) n_fail++;
    endtask
    // pin follows a register change two edges later
    task wt;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask
    task wrap;
        @(posedge aclk);
        cnt <= 16'h0000;
        @(posedge aclk);
        cnt <= 16'hffff;
        wt;
    endtask
    // a hang ends the run as a failure
    initial begin
        #1000000;
        n_fail++;
        summarize;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        chk(pin, 1);
        rdr(ST);
        chk(rd, 32'h4000_0000);
        rdr(CF);
        chk(rd, 32'h0);
        rdr(EN);
        chk(rd, 32'h0);
        rdr(8'h60);
        chk(rd, 32'h0);
        chk(resp, `RESP_SLVERR);
        wr(8'h60, 32'hffff_ffff);
        chk(resp, `RESP_SLVERR);
        wr(ST, 32'h4000_0000);
        rdr(ST);
        chk(rd, 32'h0);
        // soft request, open-drain pin pulled low
        wr(CF, 32'h0000_0100);
        wr(EN, 32'h8000_0000);
        wt;
        chk(pin, 0);
        rdr(ST);
        chk(rd, 32'h8000_0000);
        rdr(CF);
        chk(rd, 32'h0000_1100);
        wr(ST, 32'h8000_0000);
        wt;
        chk(pin, 1);
        rdr(ST);
        chk(rd, 32'h0);
        // timer wrap, push-pull active high
        wr(CF, 32'h0000_0111);
        wr(EN, 32'h8008_0000);
        wrap;
        chk(pin, 0);
        rdr(ST);
        chk(rd, 32'h0008_0000);
        @(posedge aclk) run <= 1;
        wt;
        chk(pin, 1);
        wr(CF, 32'h0000_0011);
        wt;
        chk(pin, 0);
        rdr(ST);
        chk(rd, 32'h0008_0000);
        rdr(CF);
        chk(rd, 32'h0000_1011);
        // interval of two steps withholds the pin
        wr(CF, 32'h0200_0111);
        wt;
        chk(pin, 1);
        wr(ST, 32'h0008_0000);
        wt;
        chk(pin, 0);
        rdr(CF);
        chk(rd[13], 1);
        wrap;
        chk(pin, 0);
        wr(EN, 32'h800a_0000);
        @(posedge aclk) pw <= 1;
        wt;
        chk(pin, 1);
        @(posedge aclk) pw <= 0;
        repeat (150) @(posedge aclk);
        @(negedge aclk);
        chk(pin, 0);
        repeat (80) @(posedge aclk);
        @(negedge aclk);
        chk(pin, 1);
        // zero interval releases a withheld request at once
        wr(ST, 32'h0008_0000);
        wrap;
        chk(pin, 0);
        wr(CF, 32'h0000_0111);
        wt;
        chk(pin, 1);
        // restart in mid interval of one step
        wr(CF, 32'h0100_0111);
        wr(ST, 32'h0008_0000);
        wrap;
        repeat (60) @(posedge aclk);
        wr(CF, 32'h0100_4111);
        repeat (60) @(posedge aclk);
        @(negedge aclk);
        chk(pin, 0);
        rdr(CF);
        chk(rd, 32'h0100_3111);
        repeat (60) @(posedge aclk);
        @(negedge aclk);
        chk(pin, 1);
        // crystal clock onto the pin, push-pull chosen first
        wr(ST, 32'h0008_0000);
        wr(CF, 32'h0000_0111);
        wr(CF, 32'h0000_0113);
        wt;
        n = 0;
        for (i = 0; i < 40; i++) begin
            rd[0] = pin;
            @(negedge aclk);
            n = n + (pin !== rd[0]);
        end
        chk(n > 4, 1);
        summarize;
    end
endmodule // testbench
